// ==== rtl/ssc_core.sv ====
// Purpose: status reporting side of a 16-bit spi slave with daisy chain support
// Assumes: host samples sdo on sclk rise, device shifts on sclk fall, lsb first
// Notes: snapshot and command words cross domains quasi-statically, qualified by cs
// Function
// - zero-clock frame still outputs OR of own error flag and upstream flag.
// - address lsb of 0 is flagged as protocol error; chain may mis-latch data.
// - fault after address byte stays out of current status, shows next frame.
// - no fault indication is lost when status changes during a frame.
// - new fault in addressed register during frame cancels its read-and-clear.
// - open-load or overcurrent fault during data byte omitted from current global status.
// - that same fault already shows in the current response data byte if its bit is shifted out after the second sclk rise following the fault.
// - during address byte, output error flag then global status bits.
// - access-type bit 1 means read-and-clear, 0 means plain read.
// - frame start presents OR of all error flags before any byte follows.
module ssc_core
	import ssc_pkg::*;
(
	input wire logic ref_clk_i, // system clock, 50 MHz
	input wire logic rst_i, // async reset, active high
	input wire logic sclk_i, // link serial clock
	input wire logic chip_select_low_n_i, // frame select, active low
	input wire logic sdi_i, // serial data in
	output logic sdo_o, // serial data out
	output logic sdo_oe_o, // serial out driven while selected
	input wire logic thermal_prewarning_flag_i, // level, async
	input wire logic thermal_shutdown_flag_i, // level, async
	input wire logic vs_ov_i, // supply overvoltage level, async
	input wire logic vs_uv_i, // supply undervoltage level, async
	input wire logic [31:0] diag_evt_i, // fault pulses, 8 per diag reg, ref clock
	output logic global_error_flag_o, // live error flag
	output logic [7:0] global_status_o, // live global status
	output logic load_error_flag_o // any open-load or overcurrent bit
);
	// ---------------- link domain, sampling on sclk rise
	logic frame_idle;
	logic started;
	logic [5:0] cnt, next_cnt, bit_cnt;
	logic [7:0] rx, next_rx;
	logic [7:0] addr, next_addr;
	logic got_last_address_token, next_got_last_address_token;
	logic lsb_err, next_lsb_err;
	logic tog, next_tog;

	assign frame_idle = rst_i | chip_select_low_n_i;

	always_ff @(posedge sclk_i or posedge frame_idle) begin
		if (frame_idle) begin
			started <= 1'b0;
		end else begin
			started <= 1'b1;
		end
	end

	always_comb begin
		bit_cnt = started ? cnt : 6'h00;
		next_rx = {sdi_i, rx[7:1]};
		next_cnt = (bit_cnt == SSC_CNT_MAX) ? bit_cnt : bit_cnt + 6'h01;
		next_tog = started ? tog : ~tog;
		next_got_last_address_token = started & got_last_address_token;
		next_lsb_err = started & lsb_err;
		next_addr = addr;
		if (next_cnt[2:0] == 3'h0 && !next_got_last_address_token) begin
			if (!next_rx[SSC_ADDR_ONE_POS]) begin
				next_lsb_err = 1'b1;
			end
			if (next_rx[SSC_ADDR_LAST_ADDRESS_TOKEN_POS]) begin
				next_got_last_address_token = 1'b1;
				next_addr = next_rx;
			end
		end
	end

	always_ff @(posedge sclk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt <= 6'h00;
			rx <= 8'h00;
			addr <= 8'h00;
			got_last_address_token <= 1'b0;
			lsb_err <= 1'b0;
			tog <= 1'b0;
		end else begin
			cnt <= next_cnt;
			rx <= next_rx;
			addr <= next_addr;
			got_last_address_token <= next_got_last_address_token;
			lsb_err <= next_lsb_err;
			tog <= next_tog;
		end
	end

	// live status words brought into the link domain
	logic [8*SSC_NUM_STAT-1:0] stat_live, stat_s;

	ssc_sync #(
		.WIDTH(8 * SSC_NUM_STAT),
		.RST_VAL('0)
	) u_link_sync (
		.clk_i(sclk_i),
		.rst_i(rst_i),
		.d_i(stat_live),
		.q_o(stat_s)
	);

	// ---------------- link domain, shifting on sclk fall
	logic [4:0] opos, next_opos;
	logic tx_bit, next_tx_bit;
	logic [7:0] snap;
	logic [7:0] resp_byte;
	logic resp_en;
	logic pre_bit;

	always_comb begin
		next_opos = (opos == SSC_OPOS_MAX) ? opos : opos + 5'h01;
		resp_byte = stat_s[{ssc_stat_sel(addr[6:2]), 3'b000} +: 8];
		// response covers all of the second byte, not just its first bit
		resp_en = got_last_address_token && (cnt >= 6'(SSC_BYTE_BITS)) && (cnt < 6'(2 * SSC_BYTE_BITS))
			&& ssc_is_stat(addr[6:2]);
		if (next_opos < 5'(SSC_BYTE_BITS)) begin
			next_tx_bit = snap[next_opos[2:0]];
		end else if (next_opos < 5'(2 * SSC_BYTE_BITS) && resp_en) begin
			next_tx_bit = resp_byte[next_opos[2:0]];
		end else begin
			next_tx_bit = rx[0];
		end
	end

	always_ff @(negedge sclk_i or posedge frame_idle) begin
		if (frame_idle) begin
			opos <= 5'h00;
			tx_bit <= 1'b0;
		end else begin
			opos <= next_opos;
			tx_bit <= next_tx_bit;
		end
	end

	// before the first fall the pre-frame flag drives the line
	assign sdo_o = (opos != 5'h00) ? tx_bit : pre_bit;
	assign sdo_oe_o = ~chip_select_low_n_i;

	// ---------------- reference domain
	logic [6:0] ref_s;
	logic cs_s, sdi_s, tog_s;
	logic [3:0] lvl_s;

	ssc_sync #(
		.WIDTH(7),
		.RST_VAL(SSC_CS_SYNC_RST)
	) u_ref_sync (
		.clk_i(ref_clk_i),
		.rst_i(rst_i),
		.d_i({chip_select_low_n_i, sdi_i, tog, vs_uv_i, vs_ov_i,
			thermal_shutdown_flag_i, thermal_prewarning_flag_i}),
		.q_o(ref_s)
	);

	assign cs_s = ref_s[6];
	assign sdi_s = ref_s[5];
	assign tog_s = ref_s[4];
	assign lvl_s = ref_s[3:0];

	logic cs_prev, tog_seen;
	logic [7:0] gflag, next_gflag;
	logic [7:0] diag [SSC_NUM_DIAG];
	logic [7:0] next_diag [SSC_NUM_DIAG];
	logic [SSC_NUM_STAT-1:0] evt_seen, next_evt_seen, evt_now;
	logic [7:0] next_snap, live_g;
	logic next_pre, le, clocked, bad, clr;
	logic [2:0] sel;
	logic [7:0] g_set;

	always_comb begin
		le = 1'b0;
		for (int i = 0; i < SSC_NUM_DIAG; i++) begin
			le = le | (|diag[i]);
			evt_now[i + 1] = |diag_evt_i[8*i +: 8];
		end
		g_set = {1'b0, 1'b0, lvl_s[3], lvl_s[2], 1'b0, lvl_s[1], lvl_s[0], 1'b0};
		evt_now[0] = |g_set;
		live_g = gflag;
		live_g[SSC_GS_LE] = le;
		live_g[SSC_GS_GEF] = |{live_g[7:4], ~live_g[SSC_GS_POWER_ON_INDICATOR], live_g[2:1]};
		for (int i = 0; i < SSC_NUM_DIAG; i++) begin
			stat_live[8*(i+1) +: 8] = diag[i];
		end
		stat_live[7:0] = live_g;
		// command words are static once cs is high
		clocked = tog_s != tog_seen;
		bad = clocked && ((cnt[2:0] != 3'h0) || (cnt < SSC_MIN_BITS) || lsb_err
			|| !got_last_address_token || (addr[6:2] > SSC_LAST_IDX));
		sel = ssc_stat_sel(addr[6:2]);
		clr = cs_s && !cs_prev && clocked && !bad && addr[SSC_ADDR_OP_POS]
			&& ssc_is_stat(addr[6:2]) && !(evt_seen[sel] || evt_now[sel]);
		// set wins over clear so nothing is lost
		next_gflag = gflag;
		if (clr && sel == 3'h0) begin
			next_gflag = (gflag & ~SSC_GS_CLR_MASK) | SSC_GS_POWER_ON_INDICATOR_SET;
		end
		next_gflag = next_gflag | g_set;
		next_gflag[SSC_GS_SPIERR] = next_gflag[SSC_GS_SPIERR] | (cs_s && !cs_prev && bad);
		next_gflag[SSC_GS_LE] = 1'b0;
		next_gflag[SSC_GS_GEF] = 1'b0;
		for (int i = 0; i < SSC_NUM_DIAG; i++) begin
			next_diag[i] = ((clr && sel == 3'(i + 1)) ? SSC_DIAG_RST : diag[i])
				| diag_evt_i[8*i +: 8];
		end
		next_evt_seen = (!cs_s && cs_prev) ? '0 : (evt_seen | evt_now);
		// snapshot follows live status only while deselected
		next_snap = cs_s ? live_g : snap;
		next_pre = ~cs_s & (snap[SSC_GS_GEF] | sdi_s);
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cs_prev <= 1'b1;
			tog_seen <= 1'b0;
			gflag <= SSC_GS_RST;
			for (int i = 0; i < SSC_NUM_DIAG; i++) begin
				diag[i] <= SSC_DIAG_RST;
			end
			evt_seen <= '0;
			snap <= 8'h00;
			pre_bit <= 1'b0;
			global_error_flag_o <= 1'b0;
			global_status_o <= 8'h00;
			load_error_flag_o <= 1'b0;
		end else begin
			cs_prev <= cs_s;
			tog_seen <= (cs_s && !cs_prev) ? tog_s : tog_seen;
			gflag <= next_gflag;
			for (int i = 0; i < SSC_NUM_DIAG; i++) begin
				diag[i] <= next_diag[i];
			end
			evt_seen <= next_evt_seen;
			snap <= next_snap;
			pre_bit <= next_pre;
			global_error_flag_o <= live_g[SSC_GS_GEF];
			global_status_o <= live_g;
			load_error_flag_o <= le;
		end
	end
endmodule

// ==== rtl/ssc_pkg.sv ====
// Purpose: constants and helpers for the spi status-coherence slave
// Assumes: lsb-first 16-bit frames, status registers at fixed address indexes
// Notes: global status bit 0 carries the error flag on the serial output
package ssc_pkg;
	localparam int SSC_BYTE_BITS = 8;
	localparam int SSC_NUM_DIAG = 4;
	localparam int SSC_NUM_STAT = SSC_NUM_DIAG + 1;
	// address byte fields
	localparam int SSC_ADDR_ONE_POS = 0;
	localparam int SSC_ADDR_LAST_ADDRESS_TOKEN_POS = 1;
	localparam int SSC_ADDR_OP_POS = 7;
	localparam logic [4:0] SSC_GLOBAL_IDX = 5'h0c;
	localparam logic [4:0] SSC_LAST_IDX = 5'h12;
	// global status bit positions
	localparam int SSC_GS_GEF = 0;
	localparam int SSC_GS_TPW = 1;
	localparam int SSC_GS_TSD = 2;
	localparam int SSC_GS_POWER_ON_INDICATOR = 3;
	localparam int SSC_GS_VSOV = 4;
	localparam int SSC_GS_VSUV = 5;
	localparam int SSC_GS_LE = 6;
	localparam int SSC_GS_SPIERR = 7;
	localparam logic [7:0] SSC_GS_RST = 8'h00;
	localparam logic [7:0] SSC_GS_CLR_MASK = 8'hb6;
	localparam logic [7:0] SSC_GS_POWER_ON_INDICATOR_SET = 8'h08;
	localparam logic [7:0] SSC_DIAG_RST = 8'h00;
	// frame length checks
	localparam logic [5:0] SSC_MIN_BITS = 6'h10;
	localparam logic [5:0] SSC_CNT_MAX = 6'h3f;
	localparam logic [4:0] SSC_OPOS_MAX = 5'h1f;
	localparam logic [6:0] SSC_CS_SYNC_RST = 7'h40;

	function automatic logic ssc_is_stat(input logic [4:0] idx);
		return (idx >= SSC_GLOBAL_IDX) && (idx < SSC_GLOBAL_IDX + 5'(SSC_NUM_STAT));
	endfunction

	function automatic logic [2:0] ssc_stat_sel(input logic [4:0] idx);
		return 3'(idx - SSC_GLOBAL_IDX);
	endfunction
endpackage

// ==== rtl/ssc_sync.sv ====
// Purpose: two-flop level synchroniser
// Assumes: inputs are levels or quasi-static words
// Notes: only the second stage may be read
module ssc_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk_i, // destination clock
	input wire logic rst_i, // async reset, active high
	input wire logic [WIDTH-1:0] d_i, // asynchronous input
	output logic [WIDTH-1:0] q_o // synchronised output
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta <= RST_VAL;
			q_o <= RST_VAL;
		end else begin
			meta <= d_i;
			q_o <= meta;
		end
	end
endmodule

// ==== verification/ssc_core_asserts.sv ====
// Purpose: port checks for ssc_core
// Assumes: ref clock sampling
// Notes: bound to every ssc_core
module ssc_asserts
	import ssc_pkg::*;
(
	input wire logic ref_clk_i, // clock
	input wire logic rst_i, // reset
	input wire logic sclk_i, // link clock
	input wire logic chip_select_low_n_i, // select
	input wire logic sdi_i, // serial in
	input wire logic sdo_o, // serial out
	input wire logic sdo_oe_o, // out enable
	input wire logic thermal_prewarning_flag_i, // warning level
	input wire logic [31:0] diag_evt_i, // fault pulses
	input wire logic global_error_flag_o, // error flag
	input wire logic [7:0] global_status_o, // status
	input wire logic load_error_flag_o // load flag
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	a_oe_cs: assert property (sdo_oe_o == !chip_select_low_n_i)
		else $error("sdo enable off select");
	a_zero_clk: assert property ($fell(chip_select_low_n_i) ##1
		(!chip_select_low_n_i && !sclk_i)[*6] |-> sdo_o == ($past(global_error_flag_o, 7) | sdi_i))
		else $error("pre bit wrong");
	a_power_on_indicator_gef: assert property (!global_status_o[SSC_GS_POWER_ON_INDICATOR] |-> ##[0:2] global_error_flag_o)
		else $error("flag low after power-on");
	a_spierr_gef: assert property (global_status_o[SSC_GS_SPIERR] |-> ##[0:2] global_error_flag_o)
		else $error("flag low on protocol error");
	a_evt_sets: assert property (|diag_evt_i |-> ##[1:2] load_error_flag_o)
		else $error("fault pulse lost");
	a_le_status: assert property (load_error_flag_o |-> ##[0:2] global_status_o[SSC_GS_LE])
		else $error("load bit missing");
	a_le_sticky: assert property ($fell(load_error_flag_o) |-> $past(chip_select_low_n_i))
		else $error("load flag cleared in frame");
	a_tpw_rise: assert property ($rose(thermal_prewarning_flag_i) |->
		##[1:4] global_status_o[SSC_GS_TPW]) else $error("warning not set");
	a_tpw_hold: assert property (global_status_o[SSC_GS_TPW] && thermal_prewarning_flag_i |=>
		global_status_o[SSC_GS_TPW]) else $error("warning dropped");
	c_zero: cover property ($fell(chip_select_low_n_i) ##1 (!chip_select_low_n_i && !sclk_i)[*6]);
	c_le_clr: cover property ($fell(load_error_flag_o));
	c_spierr: cover property ($rose(global_status_o[SSC_GS_SPIERR]));
endmodule
bind ssc_core ssc_asserts u_chk (.ref_clk_i, .rst_i, .sclk_i, .chip_select_low_n_i, .sdi_i,
	.sdo_o, .sdo_oe_o, .thermal_prewarning_flag_i, .diag_evt_i, .global_error_flag_o,
	.global_status_o, .load_error_flag_o);

// ==== verification/ssc_host.sv ====
// Purpose: spi master model
// Assumes: lsb first, sample on sclk rise
// Notes: sclk runs only inside frames
module ssc_host (
	output logic sclk_o, // link clock
	output logic cs_n_o, // frame select
	output logic sdi_o, // data to device
	input wire logic sdo_i // data from device
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdi_o = 1'b0;
	end
	task automatic xfer(input logic [15:0] tx, input int n, output logic pre,
		output logic [15:0] rx);
		rx = 16'h0000;
		cs_n_o = 1'b0;
		sdi_o = 1'b0;
		#200 pre = sdo_i;
		for (int i = 0; i < n; i++) begin
			sdi_o = tx[i];
			#24 sclk_o = 1'b1;
			rx[i] = sdo_i;
			#24 sclk_o = 1'b0;
		end
		#24 cs_n_o = 1'b1;
		sdi_o = ~sdi_o;
		#200;
	endtask
endmodule

// ==== verification/spi_status_report_coherence_test.sv ====
// Purpose: frame-level test of ssc_core
// Assumes: 50 MHz ref clock, 48 ns link clock
// Notes: faults injected mid data byte
module spi_status_report_coherence_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic thermal_prewarning_flag = 1'b0;
	logic [31:0] evt = 32'h0;
	logic sclk, cs_n, sdi, sdo, pre, global_error_flag, le;
	logic [7:0] gs;
	logic [15:0] rx;
	int err_count = 0;
	int comparisons = 0;
	always #10 ref_clk = ~ref_clk;
	ssc_host host (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo));
	ssc_core dut (.ref_clk_i(ref_clk), .rst_i(rst), .sclk_i(sclk), .chip_select_low_n_i(cs_n),
		.sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(), .thermal_prewarning_flag_i(thermal_prewarning_flag),
		.thermal_shutdown_flag_i(1'b0), .vs_ov_i(1'b0), .vs_uv_i(1'b0), .diag_evt_i(evt),
		.global_error_flag_o(global_error_flag), .global_status_o(gs), .load_error_flag_o(le));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task print_verdict();
		if (err_count == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// b >= 0 pulses fault bit b in the data byte
	task frame(input logic [7:0] a, input int n, input int b, input logic lvl);
		fork
			host.xfer({8'h00, a}, n, pre, rx);
			if (b >= 0) begin
				#650;
				@(negedge ref_clk);
				evt[b] = 1'b1;
				thermal_prewarning_flag = thermal_prewarning_flag | lvl;
				@(negedge ref_clk);
				evt = 32'h0;
			end
		join
	endtask
	initial begin
		repeat (5) @(negedge ref_clk);
		rst = 1'b0;
		repeat (5) @(negedge ref_clk);
		frame(8'h00, 0, -1, 0);
		chk(pre, 1'b1);
		frame(8'hb3, 16, -1, 0);
		chk({rx[7:1], pre}, 8'h01);
		chk({global_error_flag, gs}, 9'h008);
		frame(8'h00, 0, -1, 0);
		chk(pre, 1'b0);
		frame(8'h37, 16, 7, 1);
		chk({rx[7:1], pre}, 8'h08);
		chk(rx[15], 1'b1);
		frame(8'hb7, 16, 0, 0);
		chk({rx[7:1], pre}, 8'h4b);
		chk(rx[15:8], 8'h80);
		frame(8'h37, 16, -1, 0);
		chk(rx[15:8], 8'h81);
		frame(8'hb7, 16, -1, 0);
		frame(8'h37, 16, -1, 0);
		chk({le, rx[15:8]}, 9'h000);
		frame(8'h02, 16, -1, 0);
		frame(8'h33, 16, -1, 0);
		chk({rx[7:1], pre}, 8'h8b);
		print_verdict();
	end
	// about five times the expected run
	initial begin
		#50000;
		err_count++;
		print_verdict();
	end
endmodule
